// >>> sim/data_mem_model.sv
// data memory partner model with settable latency and a fault address
`timescale 1ns/1ps
module data_mem_model (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // request side
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    // settings from the bench
    input wire logic [3:0] lat_in,
    input wire logic [31:0] err_addr_in,
    // answer side
    output logic ack_out,
    output logic [31:0] rdata_out,
    output logic err_out
);
    logic [3:0] wait_q; // idle cycles spent on this request

    // one ack pulse per request after lat_in waits; junk data otherwise
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_q <= 4'h0;
            ack_out <= 1'b0;
            rdata_out <= 32'h0;
            err_out <= 1'b0;
        end else if (!ack_out && req_in && wait_q == lat_in) begin
            // data pattern tied to the address so a wrong address shows
            ack_out <= 1'b1;
            rdata_out <= {addr_in[15:0], ~addr_in[15:0]};
            err_out <= (addr_in == err_addr_in);
        end else begin
            // flip stale values so nothing read outside ack looks valid
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
            err_out <= ~err_out;
            wait_q <= (req_in && !ack_out) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> sim/load_word_zero_decode_exec_tb.sv
// self-checking bench for the load word execute unit
`timescale 1ns/1ps
module load_word_zero_decode_exec_tb;
    import ldword_pkg::*;
    logic mclk_in, rst_in, psel, penable, pwrite, pready, pslverr;
    logic ivalid, iready, mreq, mack, merr, busy, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, instr, maddr, mrdata, err_addr;
    logic [3:0] lat;
    int err_count, checks, cycles;

    load_word_zero_exec #(.REG_W(32)) dut (
        .mclk_in(mclk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .instr_valid_in(ivalid), .instr_in(instr), .instr_ready_out(iready),
        .mem_req_out(mreq), .mem_addr_out(maddr), .mem_ack_in(mack),
        .mem_rdata_in(mrdata), .mem_err_in(merr), .busy_out(busy), .irq_out(irq));

    data_mem_model mem (
        .mclk_in(mclk_in), .rst_in(rst_in), .req_in(mreq), .addr_in(maddr),
        .lat_in(lat), .err_addr_in(err_addr), .ack_out(mack), .rdata_out(mrdata),
        .err_out(merr));

    // encoders and expected values
    function automatic logic [31:0] dform(input logic [4:0] t, input logic [4:0] b, input logic [15:0] d);
        return {OP_DISP_UPD, t, b, d};
    endfunction
    function automatic logic [31:0] xform(input logic [4:0] t, input logic [4:0] b, input logic [4:0] x,
                                          input logic [9:0] xo, input logic rec);
        return {OP_EXT, t, b, x, xo, rec};
    endfunction
    function automatic logic [11:0] gaddr(input logic [4:0] n);
        return {GPR_PAGE, n, 2'b00};
    endfunction
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        penable <= 1'b0;
        @(posedge mclk_in);
        penable <= 1'b1;
        // pready, read data and error are all taken at the completing rising edge
        do @(posedge mclk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] mask,
                        input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, r & mask, exp);
    endtask

    // issue one instruction and wait until the unit is idle again
    task automatic run(input logic [31:0] w);
        @(posedge mclk_in);
        ivalid <= 1'b1;
        instr <= w;
        // request held until ready is seen high at a rising edge
        do @(posedge mclk_in); while (iready !== 1'b1);
        ivalid <= 1'b0;
        do @(posedge mclk_in); while (busy !== 1'b0);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rchk("ctrl reset", A_CTRL, 32'hffffffff, 32'h1);
        rchk("mask reset", A_MASK, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h040, 32'h0, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        $display("test reset finished");
    endtask

    task automatic t_disp_update;
        lat <= 4'h2;
        wr(gaddr(4), 32'h1000);
        run(dform(5'd6, 5'd4, 16'hfff8));
        rchk("disp upd target", gaddr(6), 32'hffffffff, word_at(32'h0ff8));
        rchk("disp upd base", gaddr(4), 32'hffffffff, 32'h0ff8);
        rchk("disp upd status", A_STATUS, 32'hffffffff, 32'h1);
        wr(gaddr(0), 32'h500);
        run(dform(5'd7, 5'd0, 16'h0010));
        rchk("disp zero base", gaddr(7), 32'hffffffff, word_at(32'h10));
        rchk("reg zero kept", gaddr(0), 32'hffffffff, 32'h500);
        $display("test displacement update finished");
    endtask

    task automatic t_idx_update;
        lat <= 4'h0;
        wr(gaddr(5), 32'h2000);
        wr(gaddr(9), 32'h24);
        run(xform(5'd6, 5'd5, 5'd9, XO_IDX_UPD, 1'b0));
        rchk("idx upd target", gaddr(6), 32'hffffffff, word_at(32'h2024));
        rchk("idx upd base", gaddr(5), 32'hffffffff, 32'h2024);
        run(xform(5'd5, 5'd5, 5'd9, XO_IDX_UPD, 1'b0));
        rchk("idx upd same reg", gaddr(5), 32'hffffffff, word_at(32'h2048));
        $display("test indexed update finished");
    endtask

    task automatic t_idx_plain;
        wr(gaddr(5), 32'h3000);
        run(xform(5'd8, 5'd5, 5'd9, XO_IDX, 1'b0));
        rchk("idx target", gaddr(8), 32'hffffffff, word_at(32'h3024));
        rchk("idx base kept", gaddr(5), 32'hffffffff, 32'h3000);
        run(xform(5'd8, 5'd0, 5'd9, XO_IDX, 1'b0));
        rchk("idx zero base", gaddr(8), 32'hffffffff, word_at(32'h24));
        $display("test plain indexed finished");
    endtask

    task automatic t_faults;
        lat <= 4'h1;
        wr(A_MASK, 32'h6);
        wr(gaddr(4), 32'h1000);
        wr(gaddr(6), 32'h0);
        run(dform(5'd6, 5'd4, 16'h0002));
        check("irq on align", {31'h0, irq}, 32'h1);
        rchk("align status", A_STATUS, 32'he, 32'h2);
        err_addr <= 32'h1010;
        @(negedge mclk_in);
        check("irq cleared", {31'h0, irq}, 32'h0);
        run(dform(5'd6, 5'd4, 16'h0010));
        rchk("storage status", A_STATUS, 32'he, 32'h4);
        rchk("fault address", A_LAST_EA, 32'hffffffff, 32'h1010);
        rchk("fault base kept", gaddr(4), 32'hffffffff, 32'h1000);
        rchk("fault target kept", gaddr(6), 32'hffffffff, 32'h0);
        $display("test faults finished");
    endtask

    task automatic t_mask_gen;
        wr(gaddr(4), 32'h14);
        wr(gaddr(5), 32'h10);
        run(xform(5'd5, 5'd6, 5'd4, XO_MASK_GEN, 1'b0));
        rchk("mask refused", A_STATUS, 32'h8, 32'h8);
        rchk("mask refused target", gaddr(6), 32'hffffffff, 32'h0);
        wr(A_CTRL, 32'h3);
        run(xform(5'd5, 5'd6, 5'd4, XO_MASK_GEN, 1'b0));
        rchk("mask ones", gaddr(6), 32'hffffffff, 32'h0000f800);
        wr(gaddr(4), 32'h10);
        wr(gaddr(5), 32'h17);
        run(xform(5'd5, 5'd6, 5'd4, XO_MASK_GEN, 1'b1));
        rchk("mask wrap", gaddr(6), 32'hffffffff, 32'hffff81ff);
        rchk("mask legal", A_STATUS, 32'h8, 32'h0);
        run({6'h20, 5'd6, 5'd4, 16'h0});
        rchk("other opcode", A_STATUS, 32'h8, 32'h8);
        $display("test mask generate finished");
    endtask

    // free running clock
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // hang guard
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict;
        end
    end

    // main sequence
    initial begin
        {psel, penable, pwrite, ivalid} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        instr = 32'h0;
        lat = 4'h0;
        err_addr = 32'h1;
        err_count = 0;
        checks = 0;
        cycles = 0;
        rst_in = 1'b1;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset;
        t_disp_update;
        t_idx_update;
        t_idx_plain;
        t_faults;
        t_mask_gen;
        print_verdict;
    end
endmodule

// >>> src/gen_reg_file.sv
// general register array, three read ports and two write ports
`timescale 1ns/1ps
module gen_reg_file #(
    parameter int REG_W = 32,
    parameter int SEL_W = 5
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // read ports
    input wire logic [SEL_W-1:0] rd0_sel_in,
    input wire logic [SEL_W-1:0] rd1_sel_in,
    input wire logic [SEL_W-1:0] rd2_sel_in,
    output logic [REG_W-1:0] rd0_data_out,
    output logic [REG_W-1:0] rd1_data_out,
    output logic [REG_W-1:0] rd2_data_out,
    // write ports, b wins on a clash
    input wire logic wa_en_in,
    input wire logic [SEL_W-1:0] wa_sel_in,
    input wire logic [REG_W-1:0] wa_data_in,
    input wire logic wb_en_in,
    input wire logic [SEL_W-1:0] wb_sel_in,
    input wire logic [REG_W-1:0] wb_data_in
);
    logic [REG_W-1:0] regs_q [2**SEL_W]; // register contents

    // reads are combinational
    assign rd0_data_out = regs_q[rd0_sel_in];
    assign rd1_data_out = regs_q[rd1_sel_in];
    assign rd2_data_out = regs_q[rd2_sel_in];

    // writes, all entries cleared on reset
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 2**SEL_W; i++) begin
                regs_q[i] <= '0;
            end
        end else begin
            if (wa_en_in) begin
                regs_q[wa_sel_in] <= wa_data_in;
            end
            if (wb_en_in) begin
                regs_q[wb_sel_in] <= wb_data_in;
            end
        end
    end
endmodule

// >>> src/ldword_pkg.sv
// shared constants for the load-word-and-zero execute unit
package ldword_pkg;
    // word and field widths
    localparam int unsigned WORD_W = 32;
    localparam int unsigned DISP_W = 16;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned XO_W = 10;
    // field positions, lsb-numbered (big-endian bit k is index 31-k)
    localparam int unsigned OP_HI = 31;
    localparam int unsigned OP_LO = 26;
    localparam int unsigned F1_HI = 25;
    localparam int unsigned F1_LO = 21;
    localparam int unsigned F2_HI = 20;
    localparam int unsigned F2_LO = 16;
    localparam int unsigned F3_HI = 15;
    localparam int unsigned F3_LO = 11;
    localparam int unsigned XO_HI = 10;
    localparam int unsigned XO_LO = 1;
    localparam int unsigned REC_BIT = 0;
    localparam int unsigned ALIGN_HI = 1;
    // opcodes
    localparam logic [5:0] OP_DISP_UPD = 6'h21;
    localparam logic [5:0] OP_EXT = 6'h1f;
    localparam logic [XO_W-1:0] XO_IDX_UPD = 10'h037;
    localparam logic [XO_W-1:0] XO_IDX = 10'h017;
    localparam logic [XO_W-1:0] XO_MASK_GEN = 10'h01d;
    // apb map
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] A_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] A_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] A_MASK = 12'h008;
    localparam logic [ADDR_W-1:0] A_LAST_EA = 12'h00c;
    localparam logic [ADDR_W-1:0] A_LAST_INSN = 12'h010;
    localparam logic [4:0] GPR_PAGE = 5'h01;
    localparam int unsigned PAGE_HI = 11;
    localparam int unsigned PAGE_LO = 7;
    localparam int unsigned GIDX_HI = 6;
    localparam int unsigned GIDX_LO = 2;
    // control bits and reset value
    localparam int unsigned CTRL_W = 2;
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_LEGACY = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;
    // event bits
    localparam int unsigned EV_W = 4;
    localparam int unsigned EV_DONE = 0;
    localparam int unsigned EV_ALIGN = 1;
    localparam int unsigned EV_DSI = 2;
    localparam int unsigned EV_ILLEGAL = 3;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_MEM = 3'b100
    } exec_state_t;
endpackage

// >>> src/load_word_zero_exec.sv
// decode and execute unit for load word and zero forms and legacy mask generate
// Operation
// (RQ1) displacement update form: opcode 33, displacement low half
// (RQ2) displacement address: base plus sign-extended displacement
// (RQ3) base update only if nonzero, differs, no fault
// (RQ4) indexed update form: opcode 31, extended 55
// (RQ5) indexed address: base plus index, or index
// (RQ6) plain indexed form: opcode 31, extended 23
// (RQ7) one form each, exception and condition untouched
// (RQ8) loaded word always goes to target register; code writes it only when the memory answer has no error
// (RQ9) mask generate: opcode 31, extended 29
// (RQ10) mask generate only in legacy mode
// (RQ11) mask from low five bits of two registers
// (RQ12) wide registers get high half cleared
`timescale 1ns/1ps
module load_word_zero_exec
    import ldword_pkg::*;
#(
    parameter int REG_W = 32
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ldword_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [ldword_pkg::WORD_W-1:0] pwdata_in,
    output logic [ldword_pkg::WORD_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // instruction stream
    input wire logic instr_valid_in,
    input wire logic [ldword_pkg::WORD_W-1:0] instr_in,
    output logic instr_ready_out,
    // data memory path
    output logic mem_req_out,
    output logic [ldword_pkg::WORD_W-1:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [ldword_pkg::WORD_W-1:0] mem_rdata_in,
    input wire logic mem_err_in,
    // status
    output logic busy_out,
    output logic irq_out
);
    import ldword_pkg::*;

    // only the two documented register widths are served
    if (REG_W != 32 && REG_W != 64) begin : g_bad_width
        $error("REG_W must be 32 or 64");
    end

    // sign-extend a displacement to a word
    function automatic logic [WORD_W-1:0] sext_disp(input logic [DISP_W-1:0] d);
        return {{(WORD_W-DISP_W){d[DISP_W-1]}}, d};
    endfunction

    // mask with ones from first to last, big-endian numbering, wrapping
    function automatic logic [WORD_W-1:0] gen_mask(input logic [SEL_W-1:0] first, input logic [SEL_W-1:0] last);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (first <= last) begin
                m[WORD_W-1-i] = (i >= first) && (i <= last);
            end else begin
                m[WORD_W-1-i] = (i >= first) || (i <= last);
            end
        end
        return m;
    endfunction

    exec_state_t state_q, state_d; // sequencer
    logic [WORD_W-1:0] instr_q; // held instruction
    logic [WORD_W-1:0] ea_q; // latched effective address
    logic [CTRL_W-1:0] ctrl_q; // run and legacy bits
    logic [EV_W-1:0] status_q; // sticky events
    logic [EV_W-1:0] mask_q; // interrupt enables
    logic [WORD_W-1:0] prdata_q; // read data captured ahead
    logic rd_ok_q; // captured gpr data is usable

    // state decode
    wire st_idle = (state_q == ST_IDLE);
    wire st_exec = (state_q == ST_EXEC);
    wire st_mem = (state_q == ST_MEM);

    // instruction fields
    wire [5:0] op_f = instr_q[OP_HI:OP_LO];
    wire [XO_W-1:0] xo_f = instr_q[XO_HI:XO_LO];
    wire [SEL_W-1:0] target_reg_field = instr_q[F1_HI:F1_LO];
    wire [SEL_W-1:0] base_reg_field = instr_q[F2_HI:F2_LO];
    wire [SEL_W-1:0] index_reg_field = instr_q[F3_HI:F3_LO];
    wire [DISP_W-1:0] disp_f = instr_q[DISP_W-1:0];
    wire record_bit = instr_q[REC_BIT]; // condition recording is not carried out here

    // (RQ1) displacement update decode
    wire legacy_load_disp_update = (op_f == OP_DISP_UPD);
    // (RQ4) indexed update decode
    wire is_idx_upd = (op_f == OP_EXT) && (xo_f == XO_IDX_UPD);
    // (RQ6) plain indexed decode
    wire legacy_load_indexed = (op_f == OP_EXT) && (xo_f == XO_IDX);
    // (RQ9) mask generate decode, fields shifted one place
    wire is_mask = (op_f == OP_EXT) && (xo_f == XO_MASK_GEN);
    wire is_load = legacy_load_disp_update || is_idx_upd || legacy_load_indexed;
    wire is_upd = legacy_load_disp_update || is_idx_upd;
    // (RQ10) mask generate refused outside legacy mode
    wire mask_ok = is_mask && ctrl_q[CTRL_LEGACY];
    wire illegal_w = !is_load && !mask_ok;

    // register file ports
    logic [REG_W-1:0] base_val, index_val, src_val;
    wire [SEL_W-1:0] apb_gidx = paddr_in[GIDX_HI:GIDX_LO];
    wire [SEL_W-1:0] portc_sel = st_exec ? target_reg_field : apb_gidx;

    // effective address
    wire base_nz = (base_reg_field != '0);
    wire [WORD_W-1:0] base_term = base_nz ? base_val[WORD_W-1:0] : '0;
    // (RQ2) displacement term, (RQ5) index term
    wire [WORD_W-1:0] off_term = legacy_load_disp_update ? sext_disp(disp_f) : index_val[WORD_W-1:0];
    wire [WORD_W-1:0] effective_addr = base_term + off_term;
    wire misaligned = (effective_addr[ALIGN_HI:0] != '0);

    // memory answer
    wire mem_done = st_mem && mem_ack_in;
    wire load_ok = mem_done && !mem_err_in;

    // (RQ11) mask from source and end low bits
    wire [WORD_W-1:0] mask_val = gen_mask(src_val[SEL_W-1:0], index_val[SEL_W-1:0]);
    wire mask_wr = st_exec && mask_ok;

    // write port a: target of a load or a mask, else apb
    // (RQ8) loaded word to target; (RQ12) high half zero
    wire exec_wa = load_ok || mask_wr;
    wire [SEL_W-1:0] exec_wa_sel = mask_wr ? base_reg_field : target_reg_field;
    wire [REG_W-1:0] exec_wa_data = mask_wr ? REG_W'(mask_val) : REG_W'(mem_rdata_in);
    // (RQ3) base update gate
    wire upd_wr = load_ok && is_upd && base_nz && (base_reg_field != target_reg_field);
    // (RQ7) no path here touches the exception or condition registers

    // apb decode
    wire apb_setup = psel_in && !penable_in;
    wire apb_access = psel_in && penable_in;
    wire hit_ctrl = (paddr_in == A_CTRL);
    wire hit_status = (paddr_in == A_STATUS);
    wire hit_mask = (paddr_in == A_MASK);
    wire hit_ea = (paddr_in == A_LAST_EA);
    wire hit_insn = (paddr_in == A_LAST_INSN);
    wire hit_gpr = (paddr_in[PAGE_HI:PAGE_LO] == GPR_PAGE) && (paddr_in[ALIGN_HI:0] == '0);
    wire mapped = hit_ctrl || hit_status || hit_mask || hit_ea || hit_insn || hit_gpr;
    // a gpr write waits while the executor owns port a; a gpr read waits for clean capture
    wire gpr_wr_stall = hit_gpr && exec_wa;
    wire ready_w = pwrite_in ? !gpr_wr_stall : (!hit_gpr || rd_ok_q);
    wire apb_fire = apb_access && ready_w;
    wire wr_fire = apb_fire && pwrite_in;
    wire status_rd = apb_fire && !pwrite_in && hit_status;
    wire apb_gpr_wr = wr_fire && hit_gpr;

    // read mux, sampled one cycle ahead of completion
    wire [WORD_W-1:0] rd_mux = hit_ctrl ? WORD_W'(ctrl_q) :
                               hit_status ? WORD_W'(status_q) :
                               hit_mask ? WORD_W'(mask_q) :
                               hit_ea ? ea_q :
                               hit_insn ? instr_q :
                               hit_gpr ? src_val[WORD_W-1:0] : '0;

    // events raised this cycle
    logic [EV_W-1:0] ev_w;
    always_comb begin
        ev_w = '0;
        ev_w[EV_DONE] = load_ok || mask_wr;
        ev_w[EV_ALIGN] = st_exec && is_load && misaligned;
        ev_w[EV_DSI] = mem_done && mem_err_in;
        ev_w[EV_ILLEGAL] = st_exec && illegal_w;
    end
    // only bits the reader actually saw are cleared
    wire [EV_W-1:0] clr_w = status_rd ? prdata_q[EV_W-1:0] : '0;

    gen_reg_file #(
        .REG_W(REG_W),
        .SEL_W(SEL_W)
    ) u_regs (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .rd0_sel_in(base_reg_field),
        .rd1_sel_in(index_reg_field),
        .rd2_sel_in(portc_sel),
        .rd0_data_out(base_val),
        .rd1_data_out(index_val),
        .rd2_data_out(src_val),
        .wa_en_in(exec_wa || apb_gpr_wr),
        .wa_sel_in(exec_wa ? exec_wa_sel : apb_gidx),
        .wa_data_in(exec_wa ? exec_wa_data : REG_W'(pwdata_in)),
        .wb_en_in(upd_wr),
        .wb_sel_in(base_reg_field),
        .wb_data_in(REG_W'(ea_q))
    );

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (instr_valid_in && instr_ready_out) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // alignment faults, masks and illegal forms finish here
                if (is_load && !misaligned) begin
                    state_d = ST_MEM;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_MEM: begin
                if (mem_ack_in) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // sequencer and instruction hold
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            instr_q <= '0;
        end else begin
            state_q <= state_d;
            if (st_idle && instr_valid_in && instr_ready_out) begin
                instr_q <= instr_in;
            end
        end
    end

    // address latch, stable for the whole memory request
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ea_q <= '0;
        end else if (st_exec && is_load) begin
            ea_q <= effective_addr;
        end
    end

    // control and mask registers
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= CTRL_RST;
            mask_q <= '0;
        end else begin
            if (wr_fire && hit_ctrl) begin
                ctrl_q <= pwdata_in[CTRL_W-1:0];
            end
            if (wr_fire && hit_mask) begin
                mask_q <= pwdata_in[EV_W-1:0];
            end
        end
    end

    // sticky status, a new event wins over the read clear
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clr_w) | ev_w;
        end
    end

    // read capture; gpr reads are unsafe while exec steals port c
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_q <= '0;
            rd_ok_q <= 1'b0;
        end else begin
            if (psel_in) begin
                prdata_q <= rd_mux;
            end
            rd_ok_q <= psel_in && !st_exec;
        end
    end

    // outputs
    assign instr_ready_out = st_idle && ctrl_q[CTRL_RUN];
    assign mem_req_out = st_mem;
    assign mem_addr_out = ea_q;
    assign busy_out = !st_idle;
    assign irq_out = |(status_q & mask_q);
    assign pready_out = apb_access && ready_w;
    assign pslverr_out = apb_access && !mapped;
    assign prdata_out = (apb_access && !pwrite_in && mapped) ? prdata_q : '0;

    // checks
    sequence s_load_exec;
        st_exec && is_load && !misaligned;
    endsequence
    sequence s_load_ack;
        st_mem && mem_ack_in && !mem_err_in;
    endsequence

    disp_decode_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ1
        (s_load_exec and (op_f == OP_DISP_UPD)) |=> st_mem && mem_req_out)
        else $error("displacement update form not issued");
    disp_addr_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ2
        (st_exec && legacy_load_disp_update) |=> mem_addr_out ==
        (($past(base_reg_field) != '0) ? $past(base_val[WORD_W-1:0]) + sext_disp($past(disp_f))
        : sext_disp($past(disp_f))))
        else $error("displacement address wrong");
    upd_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ3
        upd_wr |-> is_upd && base_nz && (base_reg_field != target_reg_field) && !mem_err_in && st_mem)
        else $error("base updated when it must not be");
    upd_take_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ3
        (s_load_ack and (is_upd && base_nz && (base_reg_field != target_reg_field))) |-> upd_wr)
        else $error("base update missed");
    idxu_decode_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ4
        (s_load_exec and (op_f == OP_EXT) && (xo_f == XO_IDX_UPD)) |=> st_mem)
        else $error("indexed update form not issued");
    idx_addr_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ5
        (st_exec && !legacy_load_disp_update && is_load) |=> mem_addr_out ==
        (($past(base_reg_field) != '0) ? $past(base_val[WORD_W-1:0]) + $past(index_val[WORD_W-1:0])
        : $past(index_val[WORD_W-1:0])))
        else $error("indexed address wrong");
    plain_idx_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ6
        (s_load_ack and legacy_load_indexed) |-> exec_wa && !upd_wr)
        else $error("plain indexed form misbehaved");
    load_wb_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ8
        s_load_ack |-> exec_wa && (exec_wa_sel == target_reg_field) &&
        (exec_wa_data[WORD_W-1:0] == mem_rdata_in) ##1 st_idle)
        else $error("loaded word not written to target");
    mask_legacy_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ10
        (st_exec && is_mask && !ctrl_q[CTRL_LEGACY]) |-> !exec_wa ##1 (st_idle && status_q[EV_ILLEGAL]))
        else $error("mask generate accepted outside legacy mode");
    mask_value_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ11
        (st_exec && mask_ok && (src_val[SEL_W-1:0] == index_val[SEL_W-1:0] + 5'h01))
        |-> exec_wa && (exec_wa_data[WORD_W-1:0] == '1))
        else $error("wrapped mask not all ones");
    high_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RQ12
        exec_wa |-> ((exec_wa_data >> WORD_W) == '0))
        else $error("high half of target not cleared");
endmodule
